// ==== hdl/sac_control.sv ====
// Control, conversion timing and readout logic of the six-channel converter.
`timescale 1ns/1ps
module sac_control
    import sac_pkg::*;
#(
    parameter int INT_CLK_DIV = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData,
    input wire logic [2:0] pairConversionStart,
    input wire logic configSourceSelect,
    input wire logic interfaceSelect,
    input wire logic widthSelect,
    input wire logic byteOrderSelect,
    input wire logic [2:0] serialLaneEnable,
    input wire logic externalConvClock,
    input wire logic parallelReadN,
    input wire logic frameSyncInput,
    input wire logic serialClock,
    input wire logic serialConfigIn,
    input wire logic [2:0][15:0] pairFirstInput,
    input wire logic [2:0][15:0] pairSecondInput,
    output logic busyIntOut,
    output logic [15:0] dataBusOut,
    output logic dataBusOe,
    output logic serialOutA,
    output logic serialOutB,
    output logic serialOutC,
    output logic refRangeHigh,
    output logic [9:0] refDacCode,
    output logic refPowerUp
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int PINS = 18;
    logic [PINS-1:0] pinMeta_reg;
    logic [PINS-1:0] pinSync_reg;
    logic [PINS-1:0] pinPrev_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
            pinPrev_reg <= '0;
        end else begin
            pinMeta_reg <= {serialLaneEnable, byteOrderSelect, widthSelect, interfaceSelect,
                configSourceSelect, serialConfigIn, serialClock, frameSyncInput,
                parallelReadN, externalConvClock, pairConversionStart, 3'h0};
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end
    logic [2:0] startSync;
    logic [2:0] startRise;
    logic extClkEdge;
    logic readFall;
    logic readRise;
    logic fsFall;
    logic fsRise;
    logic fsLow;
    logic sclkRise;
    logic sclkFall;
    logic sdiSync;
    logic swMode;
    logic serialMode;
    logic byteMode;
    logic highFirst;
    logic [2:0] laneEn;
    assign startSync = pinSync_reg[5:3];
    assign startRise = pinSync_reg[5:3] & ~pinPrev_reg[5:3];
    assign extClkEdge = pinSync_reg[6] ^ pinPrev_reg[6];
    assign readFall = ~pinSync_reg[7] & pinPrev_reg[7];
    assign readRise = pinSync_reg[7] & ~pinPrev_reg[7];
    assign fsFall = ~pinSync_reg[8] & pinPrev_reg[8];
    assign fsRise = pinSync_reg[8] & ~pinPrev_reg[8];
    assign fsLow = ~pinSync_reg[8];
    assign sclkRise = pinSync_reg[9] & ~pinPrev_reg[9];
    assign sclkFall = ~pinSync_reg[9] & pinPrev_reg[9];
    assign sdiSync = pinSync_reg[10];
    assign swMode = pinSync_reg[11];
    assign serialMode = pinSync_reg[12];
    assign byteMode = pinSync_reg[13];
    assign highFirst = pinSync_reg[14];
    assign laneEn = pinSync_reg[17:15];

    // ------------------------------------------------------------------
    // Control and auxiliary registers
    // ------------------------------------------------------------------
    logic [31:0] control_reg;
    logic [31:0] aux_reg;
    logic [31:0] cfgShift_reg;
    logic [5:0] cfgCount_reg;
    logic seqMode;
    logic useExtClk;
    assign useExtClk = swMode & control_reg[BIT_EXT_CLK];
    assign seqMode = useExtClk & control_reg[BIT_SEQ];
    // Config bits shift in on falling serial clocks.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgShift_reg <= '0;
            cfgCount_reg <= '0;
        end else if (fsFall) begin
            cfgCount_reg <= '0;
        end else if (fsLow && sclkFall && serialMode) begin
            cfgShift_reg <= {cfgShift_reg[30:0], sdiSync};
            if (cfgCount_reg != CFG_BITS) begin
                cfgCount_reg <= cfgCount_reg + 6'd1;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_reg <= CONTROL_RESET;
        end else if (regWrite && regAddr == ADDR_CONTROL) begin
            control_reg <= regWriteData;
        end else if (fsRise && serialMode && cfgCount_reg == CFG_BITS) begin
            if (!swMode) begin
                // Pin mode takes only the override bits.
                control_reg <= (control_reg & ~HW_MODE_MASK) | (cfgShift_reg & HW_MODE_MASK);
            end else if (cfgShift_reg[BIT_FULL_UPDATE]) begin
                control_reg <= cfgShift_reg;
            end else begin
                control_reg <= (control_reg & ~UPPER_MASK) | (cfgShift_reg & UPPER_MASK);
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aux_reg <= '0;
        end else if (regWrite && regAddr == ADDR_AUX) begin
            aux_reg <= regWriteData & 32'h0000_0003;
        end
    end

    // ------------------------------------------------------------------
    // Conversion clock and per-pair conversion
    // ------------------------------------------------------------------
    logic [15:0] divCount_reg;
    logic intEdge;
    logic convEdge;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCount_reg <= '0;
        end else if (intEdge) begin
            divCount_reg <= '0;
        end else begin
            divCount_reg <= divCount_reg + 16'd1;
        end
    end
    assign intEdge = (divCount_reg == 16'(INT_CLK_DIV - 1));
    assign convEdge = useExtClk ? extClkEdge : intEdge;

    logic [2:0] trigger;
    logic [2:0] active_reg;
    logic [2:0] done;
    logic [2:0][5:0] edgeCount_reg;
    logic [5:0][15:0] sample_reg;
    logic [5:0][15:0] result_reg;
    always_comb begin
        if (swMode && !seqMode) begin
            trigger = {3{startRise[0]}};
        end else begin
            trigger = startRise;
        end
    end
    assign done = active_reg & {3{convEdge}} & {edgeCount_reg[2] == CONV_EDGES - 6'd1,
        edgeCount_reg[1] == CONV_EDGES - 6'd1, edgeCount_reg[0] == CONV_EDGES - 6'd1};
    for (genvar p = 0; p < 3; p++) begin : gPair
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                active_reg[p] <= 1'b0;
                edgeCount_reg[p] <= '0;
                sample_reg[2*p] <= '0;
                sample_reg[2*p+1] <= '0;
                result_reg[2*p] <= '0;
                result_reg[2*p+1] <= '0;
            end else if (trigger[p] && !active_reg[p]) begin
                active_reg[p] <= 1'b1;
                edgeCount_reg[p] <= '0;
                sample_reg[2*p] <= pairFirstInput[p];
                sample_reg[2*p+1] <= pairSecondInput[p];
            end else if (active_reg[p] && convEdge) begin
                // The first edge after capture opens the conversion.
                edgeCount_reg[p] <= edgeCount_reg[p] + 6'd1;
                if (done[p]) begin
                    active_reg[p] <= 1'b0;
                    // Offset-binary front end codes become two's complement.
                    result_reg[2*p] <= sample_reg[2*p] ^ 16'h8000;
                    result_reg[2*p+1] <= sample_reg[2*p+1] ^ 16'h8000;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Busy and interrupt indication
    // ------------------------------------------------------------------
    logic busy_reg;
    logic intFlag_reg;
    logic [1:0] seqLow_reg;
    logic stillActive;
    logic busyFall;
    assign stillActive = |(active_reg & ~done);
    assign busyFall = busy_reg & (|done) & ~stillActive & ~(|trigger);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else if (|trigger) begin
            busy_reg <= 1'b1;
        end else if (busyFall) begin
            busy_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seqLow_reg <= '0;
        end else if (seqMode && (|done) && stillActive) begin
            seqLow_reg <= SEQ_LOW_EDGES;
        end else if (seqLow_reg != 2'd0 && convEdge) begin
            seqLow_reg <= seqLow_reg - 2'd1;
        end
    end
    // Completion wins over a start that arrives in the same cycle.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            intFlag_reg <= 1'b0;
        end else if (|done) begin
            intFlag_reg <= 1'b1;
        end else if (|trigger) begin
            intFlag_reg <= 1'b0;
        end
    end
    logic indication;
    assign indication = aux_reg[AUX_INT_MODE] ? intFlag_reg : (busy_reg & (seqLow_reg == 2'd0));
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busyIntOut <= 1'b0;
        end else begin
            busyIntOut <= indication ^ control_reg[BIT_POLARITY];
        end
    end

    // ------------------------------------------------------------------
    // Parallel readout
    // ------------------------------------------------------------------
    logic [2:0] wordIdx_reg;
    logic secondByte_reg;
    logic [15:0] curWord;
    assign curWord = result_reg[wordIdx_reg];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wordIdx_reg <= '0;
            secondByte_reg <= 1'b0;
            dataBusOut <= '0;
        end else if (busyFall) begin
            wordIdx_reg <= '0;
            secondByte_reg <= 1'b0;
        end else if (readFall && !serialMode) begin
            if (!byteMode) begin
                dataBusOut <= curWord;
            end else if (highFirst ^ secondByte_reg) begin
                dataBusOut <= {curWord[15:8], 8'h00};
            end else begin
                dataBusOut <= {curWord[7:0], 8'h00};
            end
            if (byteMode && !secondByte_reg) begin
                secondByte_reg <= 1'b1;
            end else begin
                secondByte_reg <= 1'b0;
                wordIdx_reg <= (wordIdx_reg == LAST_WORD) ? 3'd0 : wordIdx_reg + 3'd1;
            end
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataBusOe <= 1'b0;
        end else if (readFall && !serialMode) begin
            dataBusOe <= 1'b1;
        end else if (readRise || serialMode) begin
            dataBusOe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Serial readout
    // ------------------------------------------------------------------
    logic [LANE_W-1:0] laneA_reg;
    logic [LANE_W-1:0] laneB_reg;
    logic [LANE_W-1:0] laneC_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            laneA_reg <= '0;
            laneB_reg <= '0;
            laneC_reg <= '0;
        end else if (fsFall && serialMode) begin
            if (laneEn[2]) begin
                laneA_reg <= {result_reg[0], result_reg[1], 64'h0};
                laneB_reg <= {result_reg[2], result_reg[3], 64'h0};
                laneC_reg <= {result_reg[4], result_reg[5], 64'h0};
            end else if (laneEn[1]) begin
                laneA_reg <= {result_reg[0], result_reg[1], result_reg[4], 48'h0};
                laneB_reg <= {result_reg[2], result_reg[3], result_reg[5], 48'h0};
                laneC_reg <= '0;
            end else begin
                laneA_reg <= {result_reg[0], result_reg[1], result_reg[2],
                    result_reg[3], result_reg[4], result_reg[5]};
                laneB_reg <= '0;
                laneC_reg <= '0;
            end
        end else if (fsLow && sclkRise) begin
            laneA_reg <= {laneA_reg[LANE_W-2:0], 1'b0};
            laneB_reg <= {laneB_reg[LANE_W-2:0], 1'b0};
            laneC_reg <= {laneC_reg[LANE_W-2:0], 1'b0};
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serialOutA <= 1'b0;
            serialOutB <= 1'b0;
            serialOutC <= 1'b0;
        end else begin
            serialOutA <= serialMode & laneA_reg[LANE_W-1];
            serialOutB <= serialMode & laneB_reg[LANE_W-1];
            serialOutC <= serialMode & laneC_reg[LANE_W-1];
        end
    end

    // ------------------------------------------------------------------
    // Reference outputs and register reads
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refRangeHigh <= 1'b0;
            refDacCode <= '0;
            refPowerUp <= 1'b0;
        end else begin
            refRangeHigh <= control_reg[BIT_REF_HIGH];
            refDacCode <= control_reg[DAC_MSB:0];
            refPowerUp <= aux_reg[AUX_REF_POWER];
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regReadData <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                ADDR_CONTROL: regReadData <= control_reg;
                ADDR_AUX: regReadData <= aux_reg;
                ADDR_STATUS: regReadData <= {26'h0, seqMode, intFlag_reg, active_reg, busy_reg};
                default: regReadData <= '0;
            endcase
        end else begin
            regReadData <= '0;
        end
    end
endmodule : sac_control

// ==== hdl/sac_control_fix_note.sv ====
// Holds no logic.

// ==== hdl/sac_pkg.sv ====
// Constants of the converter control block.
package sac_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_AUX = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] HW_MODE_MASK = 32'h007c_e3ff;
    localparam logic [31:0] UPPER_MASK = 32'hff00_0000;
    // ------------------------------------------------------------------
    // Control and auxiliary bit positions
    // ------------------------------------------------------------------
    localparam int BIT_SEQ = 23;
    localparam int BIT_POLARITY = 20;
    localparam int BIT_REF_HIGH = 18;
    localparam int BIT_FULL_UPDATE = 16;
    localparam int BIT_EXT_CLK = 11;
    localparam int DAC_MSB = 9;
    localparam int AUX_INT_MODE = 0;
    localparam int AUX_REF_POWER = 1;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Conversion length in conversion clock edges; both edges of the external clock are counted, one edge per divider period internally.
    localparam logic [5:0] CONV_EDGES = 6'd37;
    localparam logic [1:0] SEQ_LOW_EDGES = 2'd2;
    localparam logic [5:0] CFG_BITS = 6'd32;
    localparam int LANE_W = 96;
    localparam logic [2:0] LAST_WORD = 3'd5;
endpackage : sac_pkg

// ==== verif/sac_control_props.sv ====
// Port checks of the converter control block.
`timescale 1ns/1ps
module sac_control_props
    import sac_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regReadData,
    input wire logic [2:0] pairConversionStart,
    input wire logic configSourceSelect,
    input wire logic interfaceSelect,
    input wire logic parallelReadN,
    input wire logic busyIntOut,
    input wire logic dataBusOe,
    input wire logic serialOutA,
    input wire logic serialOutB,
    input wire logic serialOutC,
    input wire logic refRangeHigh,
    input wire logic [9:0] refDacCode
);
    // ------------------------------------------------------------------
    // Register shadow and busy counter
    // ------------------------------------------------------------------
    logic [31:0] ctrlReg;
    logic auxInt;
    logic [7:0] ctrlAge;
    logic [7:0] busyCnt;
    logic busyAct;
    logic seqOn;
    logic quiet;
    // Serial updates are not shadowed.
    assign busyAct = busyIntOut ^ ctrlReg[BIT_POLARITY];
    assign seqOn = configSourceSelect & ctrlReg[BIT_SEQ] & ctrlReg[BIT_EXT_CLK];
    assign quiet = (ctrlAge > 8'h08) && !auxInt;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlReg <= CONTROL_RESET;
            auxInt <= 1'b0;
            ctrlAge <= 8'h00;
        end else if (regWrite && (regAddr == ADDR_CONTROL || regAddr == ADDR_AUX)) begin
            if (regAddr == ADDR_CONTROL) begin
                ctrlReg <= regWriteData;
            end else begin
                auxInt <= regWriteData[AUX_INT_MODE];
            end
            ctrlAge <= 8'h00;
        end else if (ctrlAge != 8'hff) begin
            ctrlAge <= ctrlAge + 8'h01;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst || !busyAct) begin
            busyCnt <= 8'h00;
        end else if (busyCnt != 8'hff) begin
            busyCnt <= busyCnt + 8'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_busy_on_start:
        assert property (quiet && ($rose(pairConversionStart[0]) || (!configSourceSelect
            && $rose(|pairConversionStart[2:1]))) |-> ##[2:5] busyAct)
        else $error("no busy after start");
    a_pair_a_only:
        assert property (quiet && configSourceSelect && !seqOn && !busyAct
            && $rose(pairConversionStart[1]) && !pairConversionStart[0] |-> ##1 !busyAct[*6])
        else $error("non-A start acted");
    a_conv_length:
        assert property (quiet && !seqOn && $fell(busyAct) |-> busyCnt >= 8'd36)
        else $error("conversion too short");
    a_busy_bounded:
        assert property (quiet |-> busyCnt < 8'd200)
        else $error("busy too long");
    a_ref_follow:
        assert property (ctrlAge > 8'h03 |-> refDacCode == ctrlReg[DAC_MSB:0]
            && refRangeHigh == ctrlReg[BIT_REF_HIGH])
        else $error("reference outputs wrong");
    a_ctrl_readback:
        assert property ($past(regRead) && $past(regAddr) == ADDR_CONTROL && ctrlAge > 8'h03
            |-> regReadData == ctrlReg)
        else $error("control readback wrong");
    a_par_serial_quiet:
        assert property (!interfaceSelect && !$past(interfaceSelect) && !$past(interfaceSelect, 2)
            && !$past(interfaceSelect, 4) |-> !(serialOutA | serialOutB | serialOutC))
        else $error("serial active in parallel");
    a_oe_on_read:
        assert property (!interfaceSelect && $fell(parallelReadN) |-> ##[1:5] dataBusOe)
        else $error("bus not driven");
    a_oe_release:
        assert property ($rose(parallelReadN) |-> ##[1:5] !dataBusOe)
        else $error("bus not released");
    c_busy_fall: cover property ($fell(busyAct));
    c_reg_start: cover property (configSourceSelect && $rose(pairConversionStart[0]));
    c_seq_start: cover property (seqOn && $rose(pairConversionStart[1]));
endmodule : sac_control_props

bind sac_control sac_control_props chk_u (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .pairConversionStart(pairConversionStart), .configSourceSelect(configSourceSelect),
    .interfaceSelect(interfaceSelect), .parallelReadN(parallelReadN),
    .busyIntOut(busyIntOut), .dataBusOe(dataBusOe), .serialOutA(serialOutA),
    .serialOutB(serialOutB), .serialOutC(serialOutC), .refRangeHigh(refRangeHigh),
    .refDacCode(refDacCode)
);

// ==== verif/sac_control_tb_top.sv ====
// Bench for the converter control block.
`timescale 1ns/1ps
module sac_control_tb_top
    import sac_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWriteData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [2:0] pairConversionStart = 3'h0;
    logic configSourceSelect = 1'b0;
    logic interfaceSelect = 1'b0;
    logic widthSelect = 1'b0;
    logic byteOrderSelect = 1'b0;
    logic [2:0] serialLaneEnable = 3'h0;
    logic externalConvClock = 1'b0;
    logic parallelReadN = 1'b1;
    logic [2:0][15:0] pairFirstInput = {16'h1234, 16'h8000, 16'hffff};
    logic [2:0][15:0] pairSecondInput = {16'hfedc, 16'h7fff, 16'h0000};
    logic hostGo = 1'b0;
    logic [6:0] hostBits = 7'h20;
    logic [31:0] regReadData, d;
    logic [15:0] dataBusOut, w;
    logic [9:0] refDacCode;
    logic busyIntOut, dataBusOe, serialOutA, serialOutB, serialOutC, refRangeHigh, refPowerUp;
    logic frameSyncInput, serialClock, serialConfigIn, hostDone;
    logic [95:0] capA, capB, capC;
    logic [15:0] e [6];
    int badCount = 0;
    int testsRun = 0;

    always #12.5 clk = ~clk;
    always #100 externalConvClock = ~externalConvClock;

    sac_control dut_u (
        .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .pairConversionStart(pairConversionStart), .configSourceSelect(configSourceSelect),
        .interfaceSelect(interfaceSelect), .widthSelect(widthSelect),
        .byteOrderSelect(byteOrderSelect), .serialLaneEnable(serialLaneEnable),
        .externalConvClock(externalConvClock), .parallelReadN(parallelReadN),
        .frameSyncInput(frameSyncInput), .serialClock(serialClock),
        .serialConfigIn(serialConfigIn), .pairFirstInput(pairFirstInput),
        .pairSecondInput(pairSecondInput), .busyIntOut(busyIntOut), .dataBusOut(dataBusOut),
        .dataBusOe(dataBusOe), .serialOutA(serialOutA), .serialOutB(serialOutB),
        .serialOutC(serialOutC), .refRangeHigh(refRangeHigh), .refDacCode(refDacCode),
        .refPowerUp(refPowerUp)
    );
    sac_host_model host_u (
        .go(hostGo), .nBits(hostBits), .cfgWord(32'h0), .sdoA(serialOutA), .sdoB(serialOutB),
        .sdoC(serialOutC), .fs(frameSyncInput), .sclk(serialClock), .serial_config_in(serialConfigIn),
        .capA(capA), .capB(capB), .capC(capC), .done(hostDone)
    );

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        testsRun++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic regWr(input logic [3:0] a, input logic [31:0] v);
        regAddr <= a;
        regWriteData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr
    task automatic regRd(input logic [3:0] a, output logic [31:0] v);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 v = regReadData;
        @(posedge clk);
    endtask : regRd
    task automatic pread(output logic [15:0] v);
        parallelReadN <= 1'b0;
        repeat (6) @(posedge clk);
        v = dataBusOut;
        parallelReadN <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : pread
    task automatic waitBusy(input logic lvl, input int lim);
        int n = 0;
        while (busyIntOut !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(96'(n < lim), 96'h1);
    endtask : waitBusy
    task automatic startPairs(input logic [2:0] m);
        pairConversionStart <= m;
        repeat (4) @(posedge clk);
        pairConversionStart <= 3'h0;
        @(posedge clk);
    endtask : startPairs
    task automatic convertAll(input logic [2:0] m);
        for (int i = 0; i < 6; i++) begin
            e[i] = ((i % 2) ? pairSecondInput[i / 2] : pairFirstInput[i / 2]) ^ 16'h8000;
        end
        startPairs(m);
        pairFirstInput <= ~pairFirstInput;
        waitBusy(1'b1, 8);
        waitBusy(1'b0, 400);
        pairFirstInput <= ~pairFirstInput;
    endtask : convertAll
    task automatic serialRead(input logic [2:0] lanes, input logic [6:0] nb);
        serialLaneEnable <= lanes;
        hostBits <= nb;
        repeat (4) @(posedge clk);
        hostGo <= 1'b1;
        @(posedge clk);
        hostGo <= 1'b0;
        for (int n = 0; n < 2000 && hostDone !== 1'b1; n++) @(posedge clk);
        check(96'(hostDone), 96'h1);
    endtask : serialRead
    task automatic completeRun();
        $display("checks %0d bad %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : completeRun

    initial begin
        #500000;
        badCount++;
        completeRun();
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check({refPowerUp, refRangeHigh, refDacCode}, 96'h0);
        regRd(4'hc, d);
        check(d, 32'h0);
        regWr(ADDR_AUX, 32'hffff_ffff);
        regWr(ADDR_CONTROL, 32'h0004_00cc);
        repeat (4) @(posedge clk);
        regRd(ADDR_CONTROL, d);
        check(d, 32'h0004_00cc);
        check({refPowerUp, refRangeHigh, refDacCode}, 12'hccc);
        regRd(ADDR_AUX, d);
        check(d, 32'h3);
        regWr(ADDR_AUX, 32'h0);
        regWr(ADDR_CONTROL, 32'h0);
        $display("registers done");
        convertAll(3'b111);
        for (int i = 0; i < 6; i++) begin
            pread(w);
            check(w, e[i]);
        end
        widthSelect <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            byteOrderSelect <= (i > 1);
            repeat (4) @(posedge clk);
            pread(w);
            check(w, {(i == 0 || i == 3) ? e[i / 2][7:0] : e[i / 2][15:8], 8'h0});
        end
        widthSelect <= 1'b0;
        $display("parallel done");
        regWr(ADDR_AUX, 32'h1);
        startPairs(3'b001);
        check(busyIntOut, 1'b0);
        waitBusy(1'b1, 400);
        pread(w);
        check(busyIntOut, 1'b1);
        regWr(ADDR_AUX, 32'h0);
        $display("interrupt done");
        interfaceSelect <= 1'b1;
        serialRead(3'b100, 7'd32);
        check({capA[31:0], capB[31:0], capC[31:0]}, {e[0], e[1], e[2], e[3], e[4], e[5]});
        serialRead(3'b010, 7'd48);
        check({capA[47:0], capB[47:0]}, {e[0], e[1], e[4], e[2], e[3], e[5]});
        serialRead(3'b000, 7'd96);
        check(capA, {e[0], e[1], e[2], e[3], e[4], e[5]});
        interfaceSelect <= 1'b0;
        $display("serial done");
        configSourceSelect <= 1'b1;
        startPairs(3'b010);
        repeat (6) @(posedge clk);
        check(busyIntOut, 1'b0);
        pairSecondInput <= {16'h0101, 16'h0202, 16'h0303};
        @(posedge clk);
        convertAll(3'b001);
        for (int i = 0; i < 6; i++) begin
            pread(w);
            check(w, e[i]);
        end
        regWr(ADDR_CONTROL, 32'h0010_0000);
        repeat (6) @(posedge clk);
        check(busyIntOut, 1'b1);
        $display("register mode done");
        // B starts while A converts.
        regWr(ADDR_CONTROL, 32'h0080_0800);
        startPairs(3'b001);
        repeat (40) @(posedge clk);
        startPairs(3'b010);
        waitBusy(1'b0, 400);
        waitBusy(1'b1, 12);
        waitBusy(1'b0, 400);
        $display("sequential done");
        completeRun();
    end
endmodule : sac_control_tb_top

// ==== verif/sac_host_model.sv ====
// Serial host model: one framed read with config word.
`timescale 1ns/1ps
module sac_host_model (
    input wire logic go,
    input wire logic [6:0] nBits,
    input wire logic [31:0] cfgWord,
    input wire logic sdoA,
    input wire logic sdoB,
    input wire logic sdoC,
    output logic fs,
    output logic sclk,
    output logic serial_config_in,
    output logic [95:0] capA,
    output logic [95:0] capB,
    output logic [95:0] capC,
    output logic done
);
    // The link clock idles high so the first fall samples the MSB.
    initial begin
        fs = 1'b1;
        sclk = 1'b1;
        serial_config_in = 1'b1;
        done = 1'b0;
    end
    always @(posedge go) begin
        done = 1'b0;
        capA = '0;
        capB = '0;
        capC = '0;
        fs = 1'b0;
        #200;
        for (int i = 0; i < nBits; i++) begin
            serial_config_in = (i < 32) ? cfgWord[31 - i] : 1'b0;
            #100;
            sclk = 1'b0;
            capA = {capA[94:0], sdoA};
            capB = {capB[94:0], sdoB};
            capC = {capC[94:0], sdoC};
            #100;
            sclk = 1'b1;
        end
        #100;
        fs = 1'b1;
        serial_config_in = ~serial_config_in;
        done = 1'b1;
    end
endmodule : sac_host_model
